//--- logic/tws_slave.sv
// Device end of the two-wire port: decodes the link, drives register access.
// Register file answers reg_rdata_i in the same cycle as reg_rd_o.
`timescale 1ns/1ps
`include "tws_defines.svh"
module tws_slave
  import tws_pkg::*;
(
  input  logic        clock_i,
  input  logic        resetn_i,
  tws_if.slave        bus,
  input  logic        address_select_pin_i,
  input  logic [15:0] reg_rdata_i,
  output logic [15:0] reg_addr_o,
  output logic [15:0] reg_wdata_o,
  output logic        reg_wr_o,
  output logic        reg_rd_o,
  output logic        busy_o
);
  tws_slv_state_t state_r;
  tws_slv_state_t state_nxt;
  logic [7:0]     shift_r;
  logic [7:0]     shift_nxt;
  logic [3:0]     bitcnt_r;
  logic [3:0]     bitcnt_nxt;
  logic [1:0]     idx_r;
  logic [1:0]     idx_nxt;
  logic [15:0]    ptr_r;
  logic [15:0]    ptr_nxt;
  logic [7:0]     whi_r;
  logic [7:0]     whi_nxt;
  logic [15:0]    rword_r;
  logic [15:0]    rword_nxt;
  logic           hi_sel_r;
  logic           hi_sel_nxt;
  logic           mack_r;
  logic           mack_nxt;
  logic [7:0]     id_r;
  logic [7:0]     id_nxt;
  logic           id_set_r;
  logic           id_set_nxt;
  logic           sda_oe_r;
  logic           sda_oe_nxt;
  logic [15:0]    raddr_r;
  logic [15:0]    raddr_nxt;
  logic [15:0]    wdata_r;
  logic [15:0]    wdata_nxt;
  logic           wr_r;
  logic           wr_nxt;
  logic           rd_r;
  logic           rd_nxt;
  logic           busy_r;
  logic           busy_nxt;
  logic           pin_meta_r;
  logic           pin_r;
  logic           sda_s;
  logic           rise;
  logic           fall;
  logic           start_ev;
  logic           stop_ev;
  logic [7:0]     own_id;
  logic [7:0]     next_byte;

  function automatic logic [15:0] inc_ptr(input logic [15:0] p);
    return p + `TWS_PTR_STEP;
  endfunction

  tws_sync u_sync
  (
    .clock_i    (clock_i),
    .resetn_i   (resetn_i),
    .scl_i      (bus.scl),
    .sda_i      (bus.sda),
    .sda_o      (sda_s),
    .scl_rise_o (rise),
    .scl_fall_o (fall),
    .start_o    (start_ev),
    .stop_o     (stop_ev)
  );

  // Open drain: the line is only ever pulled low
  assign bus.s_sda_out = `TWS_LINE_LOW;
  assign bus.s_sda_oe  = sda_oe_r;
  assign reg_addr_o    = raddr_r;
  assign reg_wdata_o   = wdata_r;
  assign reg_wr_o      = wr_r;
  assign reg_rd_o      = rd_r;
  assign busy_o        = busy_r;

  // pin choice unless software set an address
  assign own_id    = id_set_r ? id_r : (pin_r ? `TWS_ID_PIN_HI : `TWS_ID_PIN_LO);
  assign next_byte = hi_sel_r ? rword_r[7:0] : rword_r[15:8];

  always_comb
  begin
    state_nxt  = state_r;
    shift_nxt  = shift_r;
    bitcnt_nxt = bitcnt_r;
    idx_nxt    = idx_r;
    ptr_nxt    = ptr_r;
    whi_nxt    = whi_r;
    rword_nxt  = rword_r;
    hi_sel_nxt = hi_sel_r;
    mack_nxt   = mack_r;
    id_nxt     = id_r;
    id_set_nxt = id_set_r;
    sda_oe_nxt = sda_oe_r;
    raddr_nxt  = raddr_r;
    wdata_nxt  = wdata_r;
    wr_nxt     = 1'b0;
    rd_nxt     = 1'b0;
    busy_nxt   = busy_r;
    if (rd_r)
      rword_nxt = reg_rdata_i;
    // any start, repeated or not, opens an address phase
    if (start_ev)
    begin
      state_nxt  = ST_DEV;
      bitcnt_nxt = '0;
      sda_oe_nxt = 1'b0;
      busy_nxt   = 1'b1;
    end
    else if (stop_ev)
    begin
      state_nxt  = ST_IDLE;
      sda_oe_nxt = 1'b0;
      busy_nxt   = 1'b0;
    end
    else
    begin
      unique case (state_r)
        // idle waits for a start only
        ST_IDLE: ;
        ST_DEV:
        begin
          if (rise)
          begin
            shift_nxt  = {shift_r[6:0], sda_s};
            bitcnt_nxt = bitcnt_r + 1'b1;
          end
          else if (fall && bitcnt_r == `TWS_BYTE_BITS)
          begin
            if (shift_r[7:1] == own_id[7:1])
            begin
              state_nxt  = ST_DEVACK;
              sda_oe_nxt = 1'b1;
              // read fetches from the current pointer
              if (shift_r[0])
              begin
                rd_nxt    = 1'b1;
                raddr_nxt = ptr_r;
              end
            end
            else
            begin
              state_nxt = ST_IDLE;
              busy_nxt  = 1'b0;
            end
          end
        end
        ST_DEVACK:
        begin
          if (fall)
          begin
            bitcnt_nxt = '0;
            if (shift_r[0])
            begin
              // first read byte is the high byte
              state_nxt  = ST_TX;
              hi_sel_nxt = 1'b1;
              shift_nxt  = rword_r[15:8];
              sda_oe_nxt = ~rword_r[15];
            end
            else
            begin
              state_nxt  = ST_RX;
              idx_nxt    = `TWS_IDX_ADDR_HI;
              sda_oe_nxt = 1'b0;
            end
          end
        end
        ST_RX:
        begin
          if (rise)
          begin
            shift_nxt  = {shift_r[6:0], sda_s};
            bitcnt_nxt = bitcnt_r + 1'b1;
          end
          else if (fall && bitcnt_r == `TWS_BYTE_BITS)
          begin
            state_nxt  = ST_RXACK;
            sda_oe_nxt = 1'b1;
            unique case (idx_r)
              `TWS_IDX_ADDR_HI:
              begin
                ptr_nxt[15:8] = shift_r;
                idx_nxt       = `TWS_IDX_ADDR_LO;
              end
              `TWS_IDX_ADDR_LO:
              begin
                ptr_nxt[7:0] = shift_r;
                idx_nxt      = `TWS_IDX_DATA_HI;
              end
              `TWS_IDX_DATA_HI:
              begin
                whi_nxt = shift_r;
                idx_nxt = `TWS_IDX_DATA_LO;
              end
              `TWS_IDX_DATA_LO:
              begin
                wr_nxt    = 1'b1;
                raddr_nxt = ptr_r;
                wdata_nxt = {whi_r, shift_r};
                // address register also steers the decoder
                if (ptr_r == `TWS_ID_CFG_REG)
                begin
                  id_nxt     = shift_r;
                  id_set_nxt = 1'b1;
                end
                // burst continues at the next register
                ptr_nxt = inc_ptr(ptr_r);
                idx_nxt = `TWS_IDX_DATA_HI;
              end
            endcase
          end
        end
        ST_RXACK:
        begin
          // release only after the clock has fallen
          if (fall)
          begin
            state_nxt  = ST_RX;
            sda_oe_nxt = 1'b0;
            bitcnt_nxt = '0;
          end
        end
        ST_TX:
        begin
          // data moves only after a falling clock edge
          if (fall)
          begin
            if (bitcnt_r == `TWS_LAST_TX_BIT)
            begin
              state_nxt  = ST_TXACK;
              sda_oe_nxt = 1'b0;
            end
            else
            begin
              bitcnt_nxt = bitcnt_r + 1'b1;
              shift_nxt  = {shift_r[6:0], 1'b0};
              sda_oe_nxt = ~shift_r[6];
            end
          end
        end
        ST_TXACK:
        begin
          if (rise)
          begin
            mack_nxt = ~sda_s;
            // word done: advance always, prefetch only on acknowledge
            if (!hi_sel_r)
            begin
              ptr_nxt = inc_ptr(ptr_r);
              if (!sda_s)
              begin
                rd_nxt    = 1'b1;
                raddr_nxt = inc_ptr(ptr_r);
              end
            end
          end
          else if (fall)
          begin
            if (mack_r)
            begin
              state_nxt  = ST_TX;
              hi_sel_nxt = ~hi_sel_r;
              shift_nxt  = next_byte;
              sda_oe_nxt = ~next_byte[7];
              bitcnt_nxt = '0;
            end
            else
              state_nxt = ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_r    <= ST_IDLE;
      shift_r    <= '0;
      bitcnt_r   <= '0;
      idx_r      <= `TWS_IDX_ADDR_HI;
      ptr_r      <= '0;
      whi_r      <= '0;
      rword_r    <= '0;
      hi_sel_r   <= 1'b0;
      mack_r     <= 1'b0;
      id_r       <= `TWS_ID_PIN_LO;
      id_set_r   <= 1'b0;
      sda_oe_r   <= 1'b0;
      raddr_r    <= '0;
      wdata_r    <= '0;
      wr_r       <= 1'b0;
      rd_r       <= 1'b0;
      busy_r     <= 1'b0;
      pin_meta_r <= 1'b0;
      pin_r      <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      shift_r    <= shift_nxt;
      bitcnt_r   <= bitcnt_nxt;
      idx_r      <= idx_nxt;
      ptr_r      <= ptr_nxt;
      whi_r      <= whi_nxt;
      rword_r    <= rword_nxt;
      hi_sel_r   <= hi_sel_nxt;
      mack_r     <= mack_nxt;
      id_r       <= id_nxt;
      id_set_r   <= id_set_nxt;
      sda_oe_r   <= sda_oe_nxt;
      raddr_r    <= raddr_nxt;
      wdata_r    <= wdata_nxt;
      wr_r       <= wr_nxt;
      rd_r       <= rd_nxt;
      busy_r     <= busy_nxt;
      pin_meta_r <= address_select_pin_i;
      pin_r      <= pin_meta_r;
    end
  end
endmodule

//--- logic/tws_defines.svh
// Constants for both ends of the two-wire register port.
// Included by the slave, master and interface files; holds definitions only.
`ifndef TWS_DEFINES_SVH
`define TWS_DEFINES_SVH
`define TWS_ID_PIN_LO    8'h90
`define TWS_ID_PIN_HI    8'hba
`define TWS_ID_CFG_REG   16'h0004
`define TWS_BYTE_BITS    4'h8
`define TWS_LAST_TX_BIT  4'h7
`define TWS_ACK_BIT      4'h8
`define TWS_PTR_STEP     16'h0001
`define TWS_IDX_ADDR_HI  2'h0
`define TWS_IDX_ADDR_LO  2'h1
`define TWS_IDX_DATA_HI  2'h2
`define TWS_IDX_DATA_LO  2'h3
`define TWS_CLK_NS       8
`define TWS_SCL_QTR_NS   32
`define TWS_QTR_CYC      ((`TWS_SCL_QTR_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS)
`define TWS_TX_START     9'h1ff
`define TWS_TX_STOP      9'h000
`define TWS_RD_FILL      8'hff
`define TWS_LINE_LOW     1'b0
`define TWS_LINE_IDLE    1'b1
`endif

//--- logic/tws_pkg.sv
// Types shared by both ends of the two-wire register port.
// No surroundings assumed.
package tws_pkg;
  typedef enum logic [1:0] {TWS_OP_START, TWS_OP_STOP, TWS_OP_WRITE, TWS_OP_READ} tws_op_t;
  typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_DEVACK, ST_RX, ST_RXACK, ST_TX,
                            ST_TXACK} tws_slv_state_t;
  typedef enum logic {M_IDLE, M_RUN} tws_mst_state_t;
  typedef enum logic [1:0] {Q_FALL, Q_DRIVE, Q_RISE, Q_HIGH} tws_qtr_t;
endpackage

//--- logic/tws_if.sv
// Open-drain two-wire link joining master and slave ends.
// Each pin is resolved here from the drivers' enables.
`timescale 1ns/1ps
`include "tws_defines.svh"
interface tws_if;
  logic m_scl_oe;
  logic m_scl_out;
  logic m_sda_oe;
  logic m_sda_out;
  logic s_sda_oe;
  logic s_sda_out;
  logic scl;
  logic sda;

  // Released lines float high through the pull-up
  assign scl = m_scl_oe ? m_scl_out : `TWS_LINE_IDLE;
  assign sda = (m_sda_oe ? m_sda_out : `TWS_LINE_IDLE)
             & (s_sda_oe ? s_sda_out : `TWS_LINE_IDLE);

  modport master (output m_scl_oe, m_scl_out, m_sda_oe, m_sda_out, input scl, sda);
  modport slave  (output s_sda_oe, s_sda_out, input scl, sda);
endinterface

//--- logic/tws_sync.sv
// Line synchroniser and condition detector for the two-wire link.
// Inputs are asynchronous pins; outputs are on clock_i.
`timescale 1ns/1ps
module tws_sync
(
  input  logic clock_i,
  input  logic resetn_i,
  input  logic scl_i,
  input  logic sda_i,
  output logic sda_o,
  output logic scl_rise_o,
  output logic scl_fall_o,
  output logic start_o,
  output logic stop_o
);
  logic [2:0] scl_r;
  logic [2:0] sda_r;
  logic [2:0] scl_nxt;
  logic [2:0] sda_nxt;

  // Stage 0 feeds only stage 1; edges look at stages 1 and 2
  always_comb
  begin
    scl_nxt = {scl_r[1:0], scl_i};
    sda_nxt = {sda_r[1:0], sda_i};
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      scl_r <= '1;
      sda_r <= '1;
    end
    else
    begin
      scl_r <= scl_nxt;
      sda_r <= sda_nxt;
    end
  end

  assign sda_o      = sda_r[1];
  assign scl_rise_o = scl_r[1] & ~scl_r[2];
  assign scl_fall_o = ~scl_r[1] & scl_r[2];
  assign start_o    = scl_r[1] & scl_r[2] & sda_r[2] & ~sda_r[1];
  assign stop_o     = scl_r[1] & scl_r[2] & ~sda_r[2] & sda_r[1];
endmodule

//--- logic/tws_master.sv
// Host end of the two-wire port: runs one bus operation per command.
// Makes the link clock itself by dividing clock_i; no clock stretching.
`timescale 1ns/1ps
`include "tws_defines.svh"
module tws_master
  import tws_pkg::*;
(
  input  logic        clock_i,
  input  logic        resetn_i,
  tws_if.master       bus,
  input  logic        cmd_valid_i,
  input  tws_op_t     cmd_op_i,
  input  logic [7:0]  cmd_data_i,
  input  logic        cmd_ack_i,
  output logic        cmd_ready_o,
  output logic        done_o,
  output logic [7:0]  rx_data_o,
  output logic        nack_o
);
  tws_mst_state_t state_r;
  tws_mst_state_t state_nxt;
  tws_op_t        op_r;
  tws_op_t        op_nxt;
  tws_qtr_t       qtr_r;
  tws_qtr_t       qtr_nxt;
  logic [2:0]     tick_r;
  logic [2:0]     tick_nxt;
  logic [3:0]     nbit_r;
  logic [3:0]     nbit_nxt;
  logic [8:0]     tx_r;
  logic [8:0]     tx_nxt;
  logic [8:0]     rx_r;
  logic [8:0]     rx_nxt;
  logic           scl_oe_r;
  logic           scl_oe_nxt;
  logic           sda_oe_r;
  logic           sda_oe_nxt;
  logic           ready_r;
  logic           ready_nxt;
  logic           done_r;
  logic           done_nxt;
  logic [7:0]     rxd_r;
  logic [7:0]     rxd_nxt;
  logic           nack_r;
  logic           nack_nxt;
  logic           sda_s;
  logic           tick;
  logic [8:0]     rx_cap;

  tws_sync u_sync
  (
    .clock_i    (clock_i),
    .resetn_i   (resetn_i),
    .scl_i      (bus.scl),
    .sda_i      (bus.sda),
    .sda_o      (sda_s),
    .scl_rise_o (),
    .scl_fall_o (),
    .start_o    (),
    .stop_o     ()
  );

  assign bus.m_scl_out = `TWS_LINE_LOW;
  assign bus.m_sda_out = `TWS_LINE_LOW;
  assign bus.m_scl_oe  = scl_oe_r;
  assign bus.m_sda_oe  = sda_oe_r;
  assign cmd_ready_o   = ready_r;
  assign done_o        = done_r;
  assign rx_data_o     = rxd_r;
  assign nack_o        = nack_r;
  assign tick   = (tick_r == 3'(`TWS_QTR_CYC - 1));
  assign rx_cap = {rx_r[7:0], sda_s};

  always_comb
  begin
    state_nxt  = state_r;
    op_nxt     = op_r;
    qtr_nxt    = qtr_r;
    tick_nxt   = (state_r == M_IDLE || tick) ? '0 : tick_r + 1'b1;
    nbit_nxt   = nbit_r;
    tx_nxt     = tx_r;
    rx_nxt     = rx_r;
    scl_oe_nxt = scl_oe_r;
    sda_oe_nxt = sda_oe_r;
    ready_nxt  = ready_r;
    done_nxt   = 1'b0;
    rxd_nxt    = rxd_r;
    nack_nxt   = nack_r;
    unique case (state_r)
      M_IDLE:
      begin
        if (cmd_valid_i)
        begin
          state_nxt  = M_RUN;
          ready_nxt  = 1'b0;
          op_nxt     = cmd_op_i;
          qtr_nxt    = Q_FALL;
          nbit_nxt   = '0;
          scl_oe_nxt = 1'b1;
          unique case (cmd_op_i)
            TWS_OP_START: tx_nxt = `TWS_TX_START;
            TWS_OP_STOP:  tx_nxt = `TWS_TX_STOP;
            // byte MSB first, then released ack slot
            TWS_OP_WRITE: tx_nxt = {cmd_data_i, `TWS_LINE_IDLE};
            // user chooses ack or final no-acknowledge
            TWS_OP_READ:  tx_nxt = {`TWS_RD_FILL, ~cmd_ack_i};
          endcase
        end
      end
      M_RUN:
      begin
        if (tick)
        begin
          unique case (qtr_r)
            // data changes a quarter after the clock falls
            Q_FALL:
            begin
              qtr_nxt    = Q_DRIVE;
              sda_oe_nxt = ~tx_r[8];
            end
            Q_DRIVE:
            begin
              qtr_nxt    = Q_RISE;
              scl_oe_nxt = 1'b0;
            end
            Q_RISE:
            begin
              qtr_nxt = Q_HIGH;
              if (op_r == TWS_OP_START)
                sda_oe_nxt = 1'b1;
              else if (op_r == TWS_OP_STOP)
                sda_oe_nxt = 1'b0;
            end
            Q_HIGH:
            begin
              if ((op_r == TWS_OP_WRITE || op_r == TWS_OP_READ)
                  && nbit_r != `TWS_ACK_BIT)
              begin
                rx_nxt     = rx_cap;
                nbit_nxt   = nbit_r + 1'b1;
                tx_nxt     = {tx_r[7:0], 1'b0};
                qtr_nxt    = Q_FALL;
                scl_oe_nxt = 1'b1;
              end
              else
              begin
                // sampled high ack slot reports no-acknowledge
                state_nxt = M_IDLE;
                ready_nxt = 1'b1;
                done_nxt  = 1'b1;
                rx_nxt    = rx_cap;
                rxd_nxt   = rx_cap[8:1];
                nack_nxt  = sda_s;
              end
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_r  <= M_IDLE;
      op_r     <= TWS_OP_STOP;
      qtr_r    <= Q_FALL;
      tick_r   <= '0;
      nbit_r   <= '0;
      tx_r     <= '0;
      rx_r     <= '0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      ready_r  <= 1'b1;
      done_r   <= 1'b0;
      rxd_r    <= '0;
      nack_r   <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      op_r     <= op_nxt;
      qtr_r    <= qtr_nxt;
      tick_r   <= tick_nxt;
      nbit_r   <= nbit_nxt;
      tx_r     <= tx_nxt;
      rx_r     <= rx_nxt;
      scl_oe_r <= scl_oe_nxt;
      sda_oe_r <= sda_oe_nxt;
      ready_r  <= ready_nxt;
      done_r   <= done_nxt;
      rxd_r    <= rxd_nxt;
      nack_r   <= nack_nxt;
    end
  end
endmodule

//--- tb/tws_monitor.sv
// Checker for the open-drain link between master and slave ends.
// Takes the interface nets as inputs; one clock domain, no bind.
`timescale 1ns/1ps
module tws_monitor
(
  input logic clock_i,
  input logic resetn_i,
  input logic m_scl_oe,
  input logic m_sda_oe,
  input logic s_sda_oe,
  input logic scl,
  input logic sda
);
  logic       scl_q_r;
  logic       sda_q_r;
  logic [3:0] rise_r;
  logic [3:0] rise_nxt;
  logic       start_c;
  logic       stop_c;

  assign start_c = scl_q_r && scl && sda_q_r && !sda;
  assign stop_c  = scl_q_r && scl && !sda_q_r && sda;

  // Rises since the last start; ninth rise is the ack slot
  always_comb
  begin
    rise_nxt = rise_r;
    if (start_c)
      rise_nxt = 4'h0;
    else if (!scl_q_r && scl)
      rise_nxt = (rise_r == 4'h9) ? 4'h1 : rise_r + 4'h1;
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      rise_r  <= 4'h0;
    end
    else
    begin
      scl_q_r <= scl;
      sda_q_r <= sda;
      rise_r  <= rise_nxt;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  chk_scl_low_min: assert property ($rose(m_scl_oe) |-> m_scl_oe [*6])
    else $error("link clock low phase too short");
  chk_scl_high_min: assert property ($rose(scl) |-> scl [*6])
    else $error("link clock high phase too short");
  chk_one_driver: assert property (scl |-> !(m_sda_oe && s_sda_oe))
    else $error("both ends drive data while clock high");
  chk_slave_hold: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
    else $error("slave moved data while clock high");
  chk_ack_hold: assert property ($rose(s_sda_oe) && rise_r == 4'h8 |-> s_sda_oe [*8])
    else $error("slave ack not held through slot");
  chk_start_master: assert property (start_c |-> m_sda_oe && !s_sda_oe)
    else $error("start not made by master");
  chk_stop_master: assert property (stop_c |-> !m_sda_oe && $past(m_sda_oe))
    else $error("stop not made by master");
  chk_quiet_stop: assert property (stop_c |-> !s_sda_oe [*8])
    else $error("slave drives after stop");

  cover property (start_c && rise_r == 4'h1);
  cover property (stop_c);
  cover property ($rose(s_sda_oe) && rise_r == 4'h8);
endmodule

//--- tb/tb_top.sv
// Bench joining master and slave ends through the link interface.
// Drives master commands; a small register array sits behind the slave.
`timescale 1ns/1ps
module tb_top
  import tws_pkg::*;
;
  logic        clock_i   = 1'b0;
  logic        resetn_i  = 1'b0;
  logic        cmd_valid = 1'b0;
  tws_op_t     cmd_op    = TWS_OP_START;
  logic [7:0]  cmd_data  = 8'h00;
  logic        cmd_ack   = 1'b0;
  logic        pin       = 1'b0;
  logic        cmd_ready;
  logic        done;
  logic        nack;
  logic [7:0]  rx_data;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        reg_wr;
  logic        reg_rd;
  logic        busy;
  logic [15:0] mem [0:31];
  logic [7:0]  bad_id [3] = '{8'hba, 8'h92, 8'h10};
  int          failures  = 0;
  int          compares  = 0;
  int          cycles    = 0;

  always #4 clock_i = ~clock_i;

  tws_if u_tws_if ();

  tws_master u_tws_master (
    .clock_i     (clock_i),
    .resetn_i    (resetn_i),
    .bus         (u_tws_if.master),
    .cmd_valid_i (cmd_valid),
    .cmd_op_i    (cmd_op),
    .cmd_data_i  (cmd_data),
    .cmd_ack_i   (cmd_ack),
    .cmd_ready_o (cmd_ready),
    .done_o      (done),
    .rx_data_o   (rx_data),
    .nack_o      (nack)
  );

  tws_slave u_tws_slave (
    .clock_i              (clock_i),
    .resetn_i             (resetn_i),
    .bus                  (u_tws_if.slave),
    .address_select_pin_i (pin),
    .reg_rdata_i          (reg_rdata),
    .reg_addr_o           (reg_addr),
    .reg_wdata_o          (reg_wdata),
    .reg_wr_o             (reg_wr),
    .reg_rd_o             (reg_rd),
    .busy_o               (busy)
  );

  tws_monitor u_tws_monitor (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .m_scl_oe (u_tws_if.m_scl_oe),
    .m_sda_oe (u_tws_if.m_sda_oe),
    .s_sda_oe (u_tws_if.s_sda_oe),
    .scl      (u_tws_if.scl),
    .sda      (u_tws_if.sda)
  );

  // Register array answers in the cycle of the read strobe
  // Zero outside the strobe, so a lost strobe shows up as bad read data
  assign reg_rdata = (reg_rd === 1'b1) ? mem[reg_addr[4:0]] : 16'h0000;
  always @(posedge clock_i)
    if (reg_wr === 1'b1)
      mem[reg_addr[4:0]] <= reg_wdata;

  task automatic stop_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      stop_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Held until a rising edge sees ready, then wait for done
  task automatic run(input tws_op_t op, input logic [7:0] d, input logic a);
    @(negedge clock_i);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = d;
    cmd_ack = a;
    while (cmd_ready !== 1'b1)
      @(negedge clock_i);
    @(negedge clock_i);
    cmd_valid = 1'b0;
    while (done !== 1'b1)
      @(negedge clock_i);
  endtask

  task automatic wb(input logic [7:0] d, input logic nk);
    run(TWS_OP_WRITE, d, 1'b0);
    chk({15'h0000, nack}, {15'h0000, nk});
  endtask

  task automatic rb(input logic a, input logic [7:0] exp);
    run(TWS_OP_READ, 8'h00, a);
    chk({8'h00, rx_data}, {8'h00, exp});
  endtask

  task automatic id(input logic [7:0] d, input logic nk);
    run(TWS_OP_START, 8'h00, 1'b0);
    wb(d, nk);
  endtask

  task automatic sp();
    run(TWS_OP_STOP, 8'h00, 1'b0);
  endtask

  task automatic wadr(input logic [15:0] a);
    wb(a[15:8], 1'b0);
    wb(a[7:0], 1'b0);
  endtask

  initial
  begin
    for (int i = 0; i < 32; i++)
      mem[i] = 16'hc000 + 16'(i);
    repeat (5) @(posedge clock_i);
    @(negedge clock_i);
    resetn_i = 1'b1;
    id(8'h90, 1'b0);
    wadr(16'h0010);
    wadr(16'h1234);
    wadr(16'h5678);
    sp();
    chk(mem[16], 16'h1234);
    chk(mem[17], 16'h5678);
    $display("test write done");
    id(8'h90, 1'b0);
    wadr(16'h0010);
    id(8'h91, 1'b0);
    rb(1'b1, 8'h12);
    rb(1'b1, 8'h34);
    rb(1'b1, 8'h56);
    rb(1'b0, 8'h78);
    chk({15'h0000, nack}, 16'h0001);
    sp();
    $display("test random read done");
    id(8'h91, 1'b0);
    rb(1'b1, 8'hc0);
    rb(1'b0, 8'h12);
    sp();
    $display("test current read done");
    foreach (bad_id[i])
    begin
      id(bad_id[i], 1'b1);
      chk({15'h0000, busy}, 16'h0000);
      sp();
    end
    $display("test foreign id done");
    pin = 1'b1;
    repeat (4) @(negedge clock_i);
    id(8'hbb, 1'b0);
    rb(1'b1, 8'hc0);
    rb(1'b0, 8'h13);
    sp();
    id(8'h90, 1'b1);
    sp();
    id(8'hba, 1'b0);
    wadr(16'h0004);
    wadr(16'h0042);
    sp();
    id(8'hba, 1'b1);
    sp();
    id(8'h42, 1'b0);
    wadr(16'h0010);
    id(8'h43, 1'b0);
    rb(1'b0, 8'h12);
    sp();
    $display("test alternate id done");
    // Reset drops the software address; pin choice is back
    resetn_i = 1'b0;
    repeat (5) @(negedge clock_i);
    resetn_i = 1'b1;
    chk({15'h0000, busy}, 16'h0000);
    id(8'h42, 1'b1);
    sp();
    id(8'hba, 1'b0);
    chk({15'h0000, busy}, 16'h0001);
    sp();
    chk({15'h0000, busy}, 16'h0000);
    $display("test reset id done");
    stop_test();
  end
endmodule
